// file: design/tsc_pkg.sv
// Purpose: Shared constants for the temperature sensor configuration block.
// Assumes: Core clock of 125 MHz; pointer codes select registers on the link.
// Notes:   Each figure appears here once; the design refers to names only.

package tsc_pkg;

  // ----------------------------------------------------------------------
  // Register pointers
  // ----------------------------------------------------------------------
  localparam logic [7:0] PTR_CFG = 8'h01;
  localparam logic [7:0] PTR_NVCFG = 8'h11;
  localparam logic [7:0] PTR_COPY_NV2V = 8'hb8;
  localparam logic [7:0] PTR_COPY_V2NV = 8'h48;

  // ----------------------------------------------------------------------
  // Field positions (16-bit register view)
  // ----------------------------------------------------------------------
  localparam int RES_LSB = 13;
  localparam int FQ_LSB = 11;
  localparam int POL_BIT = 10;
  localparam int MODE_BIT = 9;
  localparam int SD_BIT = 8;
  localparam int LOCKDOWN_BIT = 2;
  localparam int REVERSIBLE_LOCK_BIT = 1;
  localparam int BUSY_BIT = 0;

  // Writable bits of the stored default register; the rest read as zero
  localparam logic [15:0] NV_WRITE_MASK = 16'h7f06;
  // High byte mask of the operating register: the one-shot bit reads zero
  localparam logic [7:0] CFG_HI_MASK = 8'h7f;

  // ----------------------------------------------------------------------
  // Reset and special values
  // ----------------------------------------------------------------------
  localparam logic [15:0] NV_FACTORY = 16'h0000;
  localparam logic [15:0] NV_INVALID_READ = 16'hffff;
  localparam logic [2:0] FAULT_MAX = 3'h6;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_NS = 20000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Power states, one-hot
  typedef enum logic [2:0] {
    PW_RUN = 3'b001,
    PW_DRAIN = 3'b010,
    PW_SHUT = 3'b100
  } tsc_pw_e;

  // Programming states, one-hot
  typedef enum logic [1:0] {
    NV_IDLE = 2'b01,
    NV_PROG = 2'b10
  } tsc_nv_e;

  // Consecutive faults required for a queue code
  function automatic logic [2:0] fault_depth(input logic [1:0] sel);
    case (sel)
      2'h0: fault_depth = 3'h1;
      2'h1: fault_depth = 3'h2;
      2'h2: fault_depth = 3'h4;
      default: fault_depth = 3'h6;
    endcase
  endfunction

endpackage

// file: design/tsc_config_regs.sv
// Purpose: Operating and stored default configuration of a temperature sensor.
// Assumes: A serial front end on link_clk hands over whole register accesses;
//          the conversion datapath reports conv_done, conv_fault, conv_active.
// Notes:   nv_factory_rst models the delivered state of the stored cells only.

`timescale 1ns/100ps

module tsc_config_regs
  import tsc_pkg::*;
#(
  parameter int PROG_COUNT = PROG_CYCLES
) (
  // Core clock and resets
  input wire logic clock,
  input wire logic rst,
  input wire logic nv_factory_rst,
  // Link side, runs on the serial front end clock
  input wire logic link_clk,
  input wire logic link_req,
  input wire logic link_write,
  input wire logic [7:0] link_ptr,
  input wire logic [15:0] link_wdata,
  output logic link_ready,
  output logic link_done,
  output logic link_ack,
  output logic [15:0] link_rdata,
  // Conversion datapath, core clock
  input wire logic conv_done,
  input wire logic conv_fault,
  input wire logic conv_active,
  output logic conv_run,
  output logic shutdown_active,
  output logic [1:0] resolution_sel,
  // Alarm pin and status
  output logic alert_pin,
  output logic nv_busy
);

  // ----------------------------------------------------------------------
  // Link domain: capture a request and hold it until the core answers
  // ----------------------------------------------------------------------
  logic lk_req_tgl_reg;
  logic lk_write_reg;
  logic [7:0] lk_ptr_reg;
  logic [15:0] lk_wdata_reg;
  logic lk_rs1_reg;
  logic lk_rs2_reg;
  logic lk_rs3_reg;
  logic lk_ready_reg;
  logic lk_done_reg;
  logic lk_ack_reg;
  logic [15:0] lk_rdata_reg;
  logic lk_accept;

  // Core domain answer, held stable while its toggle crosses
  logic core_srv_tgl_reg;
  logic core_ack_reg;
  logic [15:0] core_rdata_reg;

  assign lk_accept = link_req & lk_ready_reg;

  // Request bundle; data stays frozen until the answer toggle returns
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lk_req_tgl_reg <= 1'b0;
      lk_write_reg <= 1'b0;
      lk_ptr_reg <= 8'h00;
      lk_wdata_reg <= 16'h0000;
    end else if (lk_accept) begin
      lk_req_tgl_reg <= ~lk_req_tgl_reg;
      lk_write_reg <= link_write;
      lk_ptr_reg <= link_ptr;
      lk_wdata_reg <= link_wdata;
    end
  end

  // Answer toggle synchroniser; third stage only feeds the edge compare
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lk_rs1_reg <= 1'b0;
      lk_rs2_reg <= 1'b0;
      lk_rs3_reg <= 1'b0;
    end else begin
      lk_rs1_reg <= core_srv_tgl_reg;
      lk_rs2_reg <= lk_rs1_reg;
      lk_rs3_reg <= lk_rs2_reg;
    end
  end

  // Ready drops the cycle after an accept so a second request cannot slip in
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lk_ready_reg <= 1'b0;
    end else begin
      lk_ready_reg <= lk_accept ? 1'b0 : (lk_req_tgl_reg == lk_rs2_reg);
    end
  end

  // Answer capture; the core copies have been stable for two link edges
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lk_done_reg <= 1'b0;
      lk_ack_reg <= 1'b0;
      lk_rdata_reg <= 16'h0000;
    end else begin
      lk_done_reg <= lk_rs2_reg ^ lk_rs3_reg;
      if (lk_rs2_reg ^ lk_rs3_reg) begin
        lk_ack_reg <= core_ack_reg;
        lk_rdata_reg <= core_rdata_reg;
      end
    end
  end

  assign link_ready = lk_ready_reg;
  assign link_done = lk_done_reg;
  assign link_ack = lk_ack_reg;
  assign link_rdata = lk_rdata_reg;

  // ----------------------------------------------------------------------
  // Core domain: request toggle synchroniser
  // ----------------------------------------------------------------------
  logic core_rq1_reg;
  logic core_rq2_reg;
  logic load_pend_reg;
  logic serve;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_rq1_reg <= 1'b0;
      core_rq2_reg <= 1'b0;
    end else begin
      core_rq1_reg <= lk_req_tgl_reg;
      core_rq2_reg <= core_rq1_reg;
    end
  end

  // Requests wait until the reset-time copy from the stored cells is done
  assign serve = (core_rq2_reg != core_srv_tgl_reg) & ~load_pend_reg;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [15:0] nv_reg;
  logic [15:0] nv_pend_reg;
  logic [7:0] cfg_hi_reg;
  tsc_nv_e nv_state_reg;
  logic [15:0] prog_cnt_reg;
  logic busy;
  logic lockdown;
  logic locked;

  assign busy = (nv_state_reg == NV_PROG);
  assign lockdown = nv_reg[LOCKDOWN_BIT];
  assign locked = nv_reg[LOCKDOWN_BIT] | nv_reg[REVERSIBLE_LOCK_BIT];

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  logic cfg_we;
  logic [7:0] cfg_wval;
  logic prog_start;
  logic [15:0] prog_val;
  logic ack_next;
  logic [15:0] rdata_next;
  logic fault_clr;
  logic read_any;

  always_comb begin
    cfg_we = 1'b0;
    cfg_wval = 8'h00;
    prog_start = 1'b0;
    prog_val = 16'h0000;
    ack_next = 1'b0;
    rdata_next = 16'h0000;
    fault_clr = 1'b0;
    read_any = serve & ~lk_write_reg;
    case (lk_ptr_reg)
      PTR_CFG: begin
        ack_next = 1'b1;
        // Busy flag sits in bit 0, the one-shot bit always reads zero
        rdata_next = {cfg_hi_reg & CFG_HI_MASK, 7'h00, busy};
        if (serve & lk_write_reg & ~locked) begin
          cfg_we = 1'b1;
          cfg_wval = lk_wdata_reg[7:0] & CFG_HI_MASK;
          fault_clr = 1'b1;
        end
      end
      PTR_NVCFG: begin
        // Host is expected to avoid this while busy; answer reads as all ones
        rdata_next = busy ? NV_INVALID_READ : nv_reg;
        // Refused writes while busy are not acknowledged
        ack_next = ~(lk_write_reg & busy);
        if (serve & lk_write_reg & ~busy & ~lockdown) begin
          if (nv_reg[REVERSIBLE_LOCK_BIT]) begin
            // Only a cleared reversible lock bit is taken, all else kept
            prog_start = ~lk_wdata_reg[REVERSIBLE_LOCK_BIT];
            prog_val = nv_reg & ~(16'h0001 << REVERSIBLE_LOCK_BIT);
          end else begin
            prog_start = 1'b1;
            prog_val = lk_wdata_reg & NV_WRITE_MASK;
          end
        end
      end
      PTR_COPY_NV2V: begin
        ack_next = ~busy;
        if (serve & ~busy & ~locked) begin
          cfg_we = 1'b1;
          cfg_wval = nv_reg[15:8] & CFG_HI_MASK;
          fault_clr = 1'b1;
        end
      end
      PTR_COPY_V2NV: begin
        ack_next = ~busy;
        if (serve & ~busy & ~locked) begin
          prog_start = 1'b1;
          prog_val = {cfg_hi_reg, nv_reg[7:0]} & NV_WRITE_MASK;
        end
      end
      default: begin
        ack_next = 1'b0;
        rdata_next = 16'h0000;
      end
    endcase
  end

  // Answer registers and served toggle move together
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      core_srv_tgl_reg <= 1'b0;
      core_ack_reg <= 1'b0;
      core_rdata_reg <= 16'h0000;
    end else if (serve) begin
      core_srv_tgl_reg <= ~core_srv_tgl_reg;
      core_ack_reg <= ack_next;
      core_rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Stored default register and its programming cycle
  // ----------------------------------------------------------------------
  // Only the delivery reset touches the cells; the core reset leaves them
  always_ff @(posedge clock or posedge nv_factory_rst) begin
    if (nv_factory_rst) begin
      nv_reg <= NV_FACTORY;
    end else if (busy && prog_cnt_reg == 16'h0000) begin
      nv_reg <= nv_pend_reg;
    end
  end

  // Self-timed cycle; a core reset midway abandons the update
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nv_state_reg <= NV_IDLE;
      prog_cnt_reg <= 16'h0000;
      nv_pend_reg <= 16'h0000;
    end else begin
      case (nv_state_reg)
        NV_IDLE: begin
          if (prog_start) begin
            nv_state_reg <= NV_PROG;
            prog_cnt_reg <= 16'(PROG_COUNT - 1);
            nv_pend_reg <= prog_val;
          end
        end
        NV_PROG: begin
          if (prog_cnt_reg == 16'h0000) begin
            nv_state_reg <= NV_IDLE;
          end else begin
            prog_cnt_reg <= prog_cnt_reg - 16'h0001;
          end
        end
        default: begin
          nv_state_reg <= NV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Operating register
  // ----------------------------------------------------------------------
  // Async reset takes constants; the stored byte is copied on the first edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      load_pend_reg <= 1'b1;
      cfg_hi_reg <= 8'h00;
    end else if (load_pend_reg) begin
      load_pend_reg <= 1'b0;
      cfg_hi_reg <= nv_reg[15:8] & CFG_HI_MASK;
    end else if (cfg_we) begin
      cfg_hi_reg <= cfg_wval;
    end
  end

  // ----------------------------------------------------------------------
  // Fault queue and alarm
  // ----------------------------------------------------------------------
  logic [2:0] fault_cnt_reg;
  logic alarm_reg;
  logic alert_pin_reg;
  logic [2:0] depth;
  logic fault_hit;
  logic alarm_polarity;
  logic int_mode;

  assign depth = fault_depth(cfg_hi_reg[FQ_LSB-8 +: 2]);
  assign alarm_polarity = cfg_hi_reg[POL_BIT-8];
  assign int_mode = cfg_hi_reg[MODE_BIT-8];
  assign fault_hit = conv_done & conv_fault & ((fault_cnt_reg + 3'h1) >= depth);

  // Counter saturates at the deepest queue so it cannot wrap to a miss
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fault_cnt_reg <= 3'h0;
    end else if (fault_clr) begin
      fault_cnt_reg <= 3'h0;
    end else if (conv_done) begin
      if (!conv_fault) begin
        fault_cnt_reg <= 3'h0;
      end else if (fault_cnt_reg != FAULT_MAX) begin
        fault_cnt_reg <= fault_cnt_reg + 3'h1;
      end
    end
  end

  // Comparator follows conversions; interrupt latches until a register read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarm_reg <= 1'b0;
    end else if (fault_hit) begin
      alarm_reg <= 1'b1;
    end else if (!int_mode && conv_done && !conv_fault) begin
      alarm_reg <= 1'b0;
    end else if (int_mode && read_any) begin
      alarm_reg <= 1'b0;
    end
  end

  // Pin level; idle high until the stored polarity has been loaded
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alert_pin_reg <= 1'b1;
    end else begin
      alert_pin_reg <= alarm_polarity ? alarm_reg : ~alarm_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Shutdown sequencing
  // ----------------------------------------------------------------------
  tsc_pw_e pw_state_reg;
  tsc_pw_e pw_next;
  logic sd;
  logic conv_run_reg;
  logic shutdown_reg;
  logic busy_out_reg;
  logic [1:0] res_reg;

  assign sd = cfg_hi_reg[SD_BIT-8];

  always_comb begin
    pw_next = pw_state_reg;
    case (pw_state_reg)
      PW_RUN: begin
        if (sd) begin
          pw_next = PW_DRAIN;
        end
      end
      PW_DRAIN: begin
        if (!sd) begin
          pw_next = PW_RUN;
        end else if (conv_done || !conv_active) begin
          pw_next = PW_SHUT;
        end
      end
      PW_SHUT: begin
        if (!sd && !load_pend_reg) begin
          pw_next = PW_RUN;
        end
      end
      default: begin
        pw_next = PW_SHUT;
      end
    endcase
  end

  // Starts shut so nothing converts before the stored settings are in
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pw_state_reg <= PW_SHUT;
      conv_run_reg <= 1'b0;
      shutdown_reg <= 1'b1;
    end else begin
      pw_state_reg <= pw_next;
      conv_run_reg <= (pw_next == PW_RUN);
      shutdown_reg <= (pw_next == PW_SHUT);
    end
  end

  // Status outputs, registered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_out_reg <= 1'b0;
      res_reg <= 2'h0;
    end else begin
      busy_out_reg <= (nv_state_reg == NV_PROG) || prog_start;
      res_reg <= cfg_hi_reg[RES_LSB-8 +: 2];
    end
  end

  assign conv_run = conv_run_reg;
  assign shutdown_active = shutdown_reg;
  assign resolution_sel = res_reg;
  assign alert_pin = alert_pin_reg;
  assign nv_busy = busy_out_reg;

endmodule

// file: dv/tsc_config_regs_chk.sv
// Purpose: Port timing checks for the configuration block.
// Assumes: rst is asynchronous, active high, for both clocks.
// Notes:   Alarm moves away from link traffic must follow a conversion.
`timescale 1ns/100ps

module tsc_config_regs_chk
  import tsc_pkg::*;
#(
  parameter int PROG_COUNT = PROG_CYCLES
) (
  // Clocks and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  // Link handshake
  input wire logic link_req,
  input wire logic link_ready,
  input wire logic link_done,
  // Core side
  input wire logic conv_done,
  input wire logic conv_active,
  input wire logic conv_run,
  input wire logic shutdown_active,
  input wire logic alert_pin,
  input wire logic nv_busy
);
  // ----------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------
  logic [15:0] busy_cnt;
  logic [7:0] quiet_cnt;

  // Length of the current busy spell
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      busy_cnt <= 16'h0000;
    else if (nv_busy)
      busy_cnt <= busy_cnt + 16'h0001;
    else
      busy_cnt <= 16'h0000;
  end

  // Cycles since link traffic, since a register access may move the pin
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      quiet_cnt <= 8'h00;
    else if (link_req || link_done || !link_ready)
      quiet_cnt <= 8'h00;
    else if (quiet_cnt != 8'hff)
      quiet_cnt <= quiet_cnt + 8'h01;
  end

  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  property p_run_excl;
    @(posedge clock) disable iff (rst) conv_run |-> !shutdown_active;
  endproperty
  a_run_excl: assert property (p_run_excl)
    else $error("converting while shut down");

  property p_drain_first;
    @(posedge clock) disable iff (rst) $fell(conv_run) |-> !shutdown_active;
  endproperty
  a_drain_first: assert property (p_drain_first)
    else $error("shutdown without draining");

  property p_shut_cause;
    @(posedge clock) disable iff (rst) $rose(shutdown_active) |->
      $past(conv_done || !conv_active) || $past(conv_done || !conv_active, 2);
  endproperty
  a_shut_cause: assert property (p_shut_cause)
    else $error("shutdown before conversion end");

  property p_resume;
    @(posedge clock) disable iff (rst) $fell(shutdown_active) |-> ##[0:2] conv_run;
  endproperty
  a_resume: assert property (p_resume)
    else $error("no resume after shutdown");

  property p_busy_len;
    @(posedge clock) disable iff (rst) $fell(nv_busy) |->
      busy_cnt >= PROG_COUNT && busy_cnt <= PROG_COUNT + 2;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy spell wrong length");

  property p_alarm_cause;
    @(posedge clock) disable iff (rst) $changed(alert_pin) |->
      quiet_cnt < 8'h28 || $past(conv_done, 2) || $past(conv_done, 3);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause)
    else $error("alarm moved without cause");

  property p_done_pulse;
    @(posedge link_clk) disable iff (rst) link_done |=> !link_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done longer than a cycle");

  property p_answer;
    @(posedge link_clk) disable iff (rst) link_req && link_ready |-> ##[2:12] link_done;
  endproperty
  a_answer: assert property (p_answer)
    else $error("access not answered");

  // Main scenarios
  c_shut: cover property (@(posedge clock) disable iff (rst) $rose(shutdown_active));
  c_prog: cover property (@(posedge clock) disable iff (rst) $fell(nv_busy));
  c_alarm: cover property (@(posedge clock) disable iff (rst) $changed(alert_pin));
endmodule

bind tsc_config_regs tsc_config_regs_chk #(.PROG_COUNT(PROG_COUNT)) chk_i (
  .clock(clock), .rst(rst), .link_clk(link_clk), .link_req(link_req),
  .link_ready(link_ready), .link_done(link_done), .conv_done(conv_done),
  .conv_active(conv_active), .conv_run(conv_run), .shutdown_active(shutdown_active),
  .alert_pin(alert_pin), .nv_busy(nv_busy)
);

// file: dv/tsc_link_host.sv
// Purpose: Host model on the register link, one access at a time.
// Assumes: Answers come as a one-cycle done pulse on the link clock.
// Notes:   The link clock only runs during accesses and resets.
`timescale 1ns/100ps

module tsc_link_host (
  // Link clock made here
  output logic link_clk,
  // Request
  output logic link_req,
  output logic link_write,
  output logic [7:0] link_ptr,
  output logic [15:0] link_wdata,
  // Answer
  input wire logic link_ready,
  input wire logic link_done,
  input wire logic link_ack,
  input wire logic [15:0] link_rdata
);
  bit clk_on = 1'b0;

  // Gated clock, parked low so no stray edge falls between accesses
  initial begin
    link_clk = 1'b0;
    link_req = 1'b0;
    link_write = 1'b0;
    link_ptr = 8'h00;
    link_wdata = 16'h0000;
    #3;
    forever begin
      #32;
      link_clk = clk_on ? ~link_clk : 1'b0;
    end
  end

  // Request held until taken, answer taken at the done edge
  task automatic xfer(input logic wr, input logic [7:0] p, input logic [15:0] d,
                      output logic ack, output logic [15:0] rd);
    int n;
    n = 0;
    clk_on = 1'b1;
    @(posedge link_clk) #1;
    link_req = 1'b1;
    link_write = wr;
    link_ptr = p;
    link_wdata = d;
    do begin
      @(posedge link_clk);
      n++;
    end while (link_ready !== 1'b1 && n < 64);
    #1;
    link_req = 1'b0;
    // Released lines show the inverse so stale values never pass
    link_write = ~wr;
    link_ptr = ~p;
    link_wdata = ~d;
    do begin
      @(posedge link_clk);
      n++;
    end while (link_done !== 1'b1 && n < 64);
    ack = link_ack;
    rd = link_rdata;
    // A missing answer hands back unknowns so no stale value can pass
    if (link_done !== 1'b1) begin
      ack = 1'bx;
      rd = 16'hxxxx;
    end
    repeat (2) @(posedge link_clk);
    clk_on = 1'b0;
  endtask
endmodule

// file: dv/tsc_config_regs_tb.sv
// Purpose: Self-checking bench for the configuration register block.
// Assumes: The host model makes the link clock; conversions driven here.
// Notes:   Programming cut to 600 core cycles to keep the run short.
`timescale 1ns/100ps

module tsc_config_regs_tb
  import tsc_pkg::*;
;
  logic clock, rst, nv_factory_rst, link_clk, link_req, link_write;
  logic [7:0] link_ptr;
  logic [15:0] link_wdata, link_rdata, rdat;
  logic link_ready, link_done, link_ack, ack, conv_done, conv_fault, conv_active;
  logic conv_run, shutdown_active, alert_pin, nv_busy;
  logic [1:0] resolution_sel;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  int dep [4] = '{1, 2, 4, 6};

  // Block under test and link host
  tsc_config_regs #(.PROG_COUNT(600)) uut (
    .clock(clock), .rst(rst), .nv_factory_rst(nv_factory_rst), .link_clk(link_clk),
    .link_req(link_req), .link_write(link_write), .link_ptr(link_ptr),
    .link_wdata(link_wdata), .link_ready(link_ready), .link_done(link_done),
    .link_ack(link_ack), .link_rdata(link_rdata), .conv_done(conv_done),
    .conv_fault(conv_fault), .conv_active(conv_active), .conv_run(conv_run),
    .shutdown_active(shutdown_active), .resolution_sel(resolution_sel),
    .alert_pin(alert_pin), .nv_busy(nv_busy));
  tsc_link_host host (
    .link_clk(link_clk), .link_req(link_req), .link_write(link_write),
    .link_ptr(link_ptr), .link_wdata(link_wdata), .link_ready(link_ready),
    .link_done(link_done), .link_ack(link_ack), .link_rdata(link_rdata));

  // Core clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Access, then a quiet gap so the alarm settles away from link traffic
  task automatic acc(input logic w, input logic [7:0] p, input logic [15:0] d);
    host.xfer(w, p, d, ack, rdat);
    repeat (40) @(posedge clock);
  endtask

  task automatic rdc(input logic [7:0] p, input logic [15:0] exp, input string what);
    acc(1'b0, p, 16'h0000);
    chk(rdat, exp, what);
  endtask

  // One finished conversion, alarm looked at once settled
  task automatic conv(input logic f);
    @(posedge clock) #1;
    conv_done = 1'b1;
    conv_fault = f;
    @(posedge clock) #1;
    conv_done = 1'b0;
    repeat (4) @(posedge clock) #1;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (nv_busy !== 1'b0 && n < 5000) begin
      @(posedge clock) #1;
      n++;
    end
  endtask

  task automatic do_reset(input logic factory);
    rst = 1'b1;
    nv_factory_rst = factory;
    host.clk_on = 1'b1;
    repeat (16) @(posedge clock) #1;
    rst = 1'b0;
    nv_factory_rst = 1'b0;
    repeat (8) @(posedge clock) #1;
    host.clk_on = 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      $display("mismatch at %0t: run hung", $time);
      wrap_up();
    end
  end

  initial begin
    conv_done = 1'b0;
    conv_fault = 1'b0;
    conv_active = 1'b1;
    do_reset(1'b1);
    rdc(PTR_CFG, 16'h0000, "cfg default");
    rdc(PTR_NVCFG, 16'h0000, "stored default");
    chk(16'(alert_pin), 16'h0001, "alarm idle");
    chk(16'(conv_run), 16'h0001, "running");
    $display("test defaults done");
    // Every queue code; from code 1 on, a fault then a clean conversion first restarts the count
    for (int q = 0; q < 4; q++) begin
      acc(1'b1, PTR_CFG, {11'h000, q[1:0], 3'h0});
      if (q != 0) begin
        conv(1'b1);
        conv(1'b0);
      end
      for (int i = 1; i < dep[q]; i++) begin
        conv(1'b1);
        chk(16'(alert_pin), 16'h0001, "alarm early");
      end
      conv(1'b1);
      chk(16'(alert_pin), 16'h0000, "alarm at depth");
      conv(1'b0);
      chk(16'(alert_pin), 16'h0001, "alarm cleared");
    end
    $display("test fault queue done");
    acc(1'b1, PTR_CFG, 16'h0006);
    chk(16'(alert_pin), 16'h0000, "high idle");
    conv(1'b1);
    chk(16'(alert_pin), 16'h0001, "high alarm");
    conv(1'b0);
    chk(16'(alert_pin), 16'h0001, "latched alarm");
    rdc(PTR_CFG, 16'h0600, "cfg polarity mode");
    chk(16'(alert_pin), 16'h0000, "read clears");
    $display("test polarity mode done");
    acc(1'b1, PTR_CFG, 16'h0001);
    chk(16'(conv_run), 16'h0000, "drain stops");
    chk(16'(shutdown_active), 16'h0000, "drain waits");
    conv(1'b0);
    chk(16'(shutdown_active), 16'h0001, "shut after conv");
    acc(1'b1, PTR_CFG, 16'h0000);
    chk(16'(conv_run), 16'h0001, "resumed");
    $display("test shutdown done");
    acc(1'b1, PTR_NVCFG, 16'hf5f9);
    chk(16'(ack), 16'h0001, "program ack");
    chk(16'(nv_busy), 16'h0001, "busy pin");
    rdc(PTR_CFG, 16'h0001, "busy shown");
    acc(1'b1, PTR_NVCFG, 16'h0002);
    chk(16'(ack), 16'h0000, "busy write");
    acc(1'b1, PTR_COPY_V2NV, 16'h0000);
    chk(16'(ack), 16'h0000, "busy copy");
    wait_idle();
    rdc(PTR_CFG, 16'h0000, "busy gone");
    rdc(PTR_NVCFG, 16'h7500, "stored layout");
    $display("test programming done");
    do_reset(1'b0);
    rdc(PTR_CFG, 16'h7500, "reloaded cfg");
    chk(16'(rdat[12:11]), 16'h0002, "queue reload");
    chk(16'(rdat[9]), 16'h0000, "mode reload");
    chk(16'(alert_pin), 16'h0000, "polarity reload");
    chk(16'(conv_run), 16'h0000, "shutdown reload");
    chk(16'(resolution_sel), 16'h0003, "resolution reload");
    rdc(PTR_NVCFG, 16'h7500, "kept over reset");
    $display("test reload done");
    acc(1'b1, PTR_NVCFG, 16'h7502);
    wait_idle();
    acc(1'b1, PTR_CFG, 16'h0000);
    chk(16'(ack), 16'h0001, "locked ack");
    rdc(PTR_CFG, 16'h7500, "locked cfg");
    acc(1'b1, PTR_NVCFG, 16'h0000);
    wait_idle();
    rdc(PTR_NVCFG, 16'h7500, "unlock only");
    acc(1'b1, PTR_NVCFG, 16'h0004);
    wait_idle();
    acc(1'b1, PTR_NVCFG, 16'h0000);
    wait_idle();
    rdc(PTR_NVCFG, 16'h0004, "lockdown kept");
    acc(1'b1, PTR_CFG, 16'h001f);
    rdc(PTR_CFG, 16'h7500, "lockdown cfg");
    rdc(8'h5a, 16'h0000, "unknown pointer");
    chk(16'(ack), 16'h0000, "unknown nack");
    $display("test locks done");
    wrap_up();
  end
endmodule
